// file: shared/bms_pkg.sv
// Constants, types and register layout shared by the boot mode sequencer.
// How it works
// (R01) Hold everything while the reset pin is low.
// (R02) Three boot modes: host, ROM copy, none.
// (R03) Host boot stalls the CPU, releases the rest.
// (R04) Host path: host port or PCI by strap.
// (R05) Host sets the wake bit when loading ends.
// (R06) Wake bit in host boot releases the CPU.
// (R07) Wake ends stall unlatched, only in host boot.
// (R08) Host may read and write memory while stalled.
// (R09) No new wake interrupt until wake bit cleared.
// (R10) ROM boot copies 1 KB from region one.
// (R11) Consecutive ROM bytes packed into 32-bit words.
// (R12) Copy done releases the CPU at address 0.
// (R13) ROM image stored in system byte order.
// (R14) No boot runs straight from address 0.
// (R15) Four 256M chip-enable regions from 8000 0000.
// (R16) Region one spans 9000 0000 to 9FFF FFFF.
// (R17) Internal memory always sits at address 0.
// (R18) Straps captured at release, held until reset.
package bms_pkg;

   // Boot mode strap codes
   localparam logic [1:0]  BMS_BOOT_NONE   = 2'h0;
   localparam logic [1:0]  BMS_BOOT_HOST   = 2'h1;
   localparam logic [1:0]  BMS_BOOT_ROM    = 2'h2;

   // Address map
   localparam logic [31:0] BMS_IMEM_BASE   = 32'h0000_0000;
   localparam logic [31:0] BMS_CPU_START   = 32'h0000_0000;
   localparam logic [1:0]  BMS_EXT_TOP     = 2'h2;
   localparam int          BMS_CE_SHIFT    = 28;
   localparam logic [31:0] BMS_CE1_BASE    = 32'h9000_0000;
   localparam logic [31:0] BMS_CE1_LAST    = 32'h9FFF_FFFF;

   // ROM image size
   localparam int          BMS_ROM_BYTES   = 1024;
   localparam logic [9:0]  BMS_LAST_BYTE   = 10'h3FF;

   // Register offsets
   localparam logic [31:0] BMS_HPC_OFFS    = 32'h0000_0000;
   localparam logic [31:0] BMS_STAT_OFFS   = 32'h0000_0004;

   // Field positions
   localparam int          BMS_WAKE_POS    = 0;
   localparam int          BMS_ST_STALL    = 0;
   localparam int          BMS_ST_HOST     = 1;
   localparam int          BMS_ST_COPY     = 2;
   localparam int          BMS_ST_PCI      = 3;
   localparam int          BMS_ST_MODE     = 4;
   localparam int          BMS_ST_BIGEND   = 6;

   // Values after reset
   localparam logic        BMS_WAKE_RST    = 1'b0;
   localparam logic [1:0]  BMS_MODE_RST    = 2'h0;

   // Sequencer states
   typedef enum logic [2:0]
   {
      BMS_ST_RESET,
      BMS_ST_HOST_WAIT,
      BMS_ST_ROM_READ,
      BMS_ST_ROM_WRITE,
      BMS_ST_RUN
   } bms_state_e;

   // ROM byte read request
   typedef struct packed
   {
      logic        rd;
      logic [31:0] addr;
   } bms_rom_req_s;

   // Internal memory word write request
   typedef struct packed
   {
      logic        wr;
      logic [31:0] addr;
      logic [31:0] data;
   } bms_mem_req_s;

endpackage

// file: rtl/bms_sync.sv
// Two flip-flop synchroniser for pin inputs.
module bms_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;   // First stage, read only by second
   logic [WIDTH-1:0] sync_q;   // Second stage

   // Both stages clear on reset
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

// file: rtl/bms_top.sv
// Boot mode sequencer: reset hold, boot mode control, ROM copy and region decode.
//
// Local design decisions: the register layout and the APB register port.
module bms_top (
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   // Pins, asynchronous
   input  wire logic                  reset_pin_n,
   input  wire logic [1:0]            boot_mode_pin,
   input  wire logic                  pci_sel_pin,
   input  wire logic                  big_endian_pin,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Device control
   output logic                       periph_rst,
   output logic                       cpu_stall,
   output logic                       cpu_start,
   output logic      [31:0]           cpu_start_addr,
   output logic                       cpu_wake_irq,
   output logic                       host_port_en,
   output logic                       pci_en,
   output logic                       host_mem_en,
   // ROM byte reads over the external memory port
   output bms_pkg::bms_rom_req_s      rom_req,
   input  wire logic [7:0]            rom_data,
   input  wire logic                  rom_ack,
   // Internal memory writes
   output bms_pkg::bms_mem_req_s      mem_req,
   input  wire logic                  mem_ack,
   // Chip-enable region decoder
   input  wire logic [31:0]           dec_addr,
   output logic      [3:0]            dec_sel
);
   import bms_pkg::*;

   // One-hot chip-enable region of an address, zero outside
   function automatic logic [3:0] ce_decode(input logic [31:0] a);
      logic [3:0] sel;
      sel = 4'h0;
      if (a[31:30] == BMS_EXT_TOP)
      begin
         sel[a[BMS_CE_SHIFT+1:BMS_CE_SHIFT]] = 1'b1;
      end
      return sel;
   endfunction

   // Synchronised pins
   logic [4:0]   pins_s;
   logic         rst_rel_s;      // Reset pin released
   logic [1:0]   mode_s;
   logic         pci_s;
   logic         bige_s;

   bms_sync #(.WIDTH(5)) u_sync (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .async_in ({big_endian_pin, pci_sel_pin, boot_mode_pin, reset_pin_n}),
      .sync_out (pins_s)
   );

   assign rst_rel_s = pins_s[0];
   assign mode_s    = pins_s[2:1];
   assign pci_s     = pins_s[3];
   assign bige_s    = pins_s[4];

   // Sequencer state
   bms_state_e   state_q, state_d;
   logic [1:0]   mode_q, mode_d;       // Captured boot mode
   logic         pci_q, pci_d;         // Captured host path
   logic         bige_q, bige_d;       // Captured byte order
   logic [9:0]   cnt_q, cnt_d;         // ROM byte index
   logic [31:0]  word_q, word_d;       // Packing register
   logic         wake_q, wake_d;       // Wake bit
   logic         irq_q, irq_d;
   logic         start_q, start_d;
   logic         stall_q, stall_d;
   logic         prst_q, prst_d;
   logic         hpe_q, hpe_d;
   logic         pcie_q, pcie_d;
   logic         hme_q, hme_d;
   bms_rom_req_s rom_q, rom_d;
   bms_mem_req_s mem_q, mem_d;
   logic [3:0]   sel_q, sel_d;

   // APB state
   logic         rdy_q, rdy_d;
   logic         err_q, err_d;
   logic [31:0]  rdat_q, rdat_d;
   logic         acc;            // First access cycle
   logic         done;           // Completing edge
   logic         hit_hpc;
   logic         hit_stat;
   logic         wake_rise;

   // APB decode
   assign acc       = psel & penable & ~rdy_q;
   assign done      = psel & penable & rdy_q;
   assign hit_hpc   = (paddr == BMS_HPC_OFFS);
   assign hit_stat  = (paddr == BMS_STAT_OFFS);
   // Host completes its load by writing one to the wake bit [R05]
   assign wake_rise = done & pwrite & hit_hpc & pwdata[BMS_WAKE_POS] & ~wake_q;

   // APB answer: one wait state, unmapped gives error
   always_comb
   begin
      rdy_d  = acc;
      err_d  = 1'b0;
      rdat_d = rdat_q;
      if (acc)
      begin
         err_d  = ~(hit_hpc | hit_stat);
         rdat_d = 32'h0000_0000;
         if (!pwrite && hit_hpc)
         begin
            rdat_d[BMS_WAKE_POS] = wake_q;
         end
         else if (!pwrite && hit_stat)
         begin
            rdat_d[BMS_ST_STALL]             = stall_q;
            rdat_d[BMS_ST_HOST]              = (mode_q == BMS_BOOT_HOST);
            rdat_d[BMS_ST_COPY]              = (state_q == BMS_ST_ROM_READ) |
                                               (state_q == BMS_ST_ROM_WRITE);
            rdat_d[BMS_ST_PCI]               = pci_q;
            rdat_d[BMS_ST_MODE+1:BMS_ST_MODE] = mode_q;
            rdat_d[BMS_ST_BIGEND]            = bige_q;
         end
      end
   end

   // Sequencer next state
   always_comb
   begin
      state_d = state_q;
      mode_d  = mode_q;
      pci_d   = pci_q;
      bige_d  = bige_q;
      cnt_d   = cnt_q;
      word_d  = word_q;
      irq_d   = 1'b0;
      start_d = 1'b0;
      rom_d   = rom_q;
      mem_d   = mem_q;
      // Wake bit written by host, cleared by CPU
      wake_d  = (done && pwrite && hit_hpc) ? pwdata[BMS_WAKE_POS] : wake_q;
      if (!rst_rel_s)
      begin
         // Pin low: back to the reset state [R01]
         state_d = BMS_ST_RESET;
         wake_d  = BMS_WAKE_RST;
         rom_d   = '0;
         mem_d   = '0;
      end
      else
      begin
         unique case (state_q)
            BMS_ST_RESET:
            begin
               // Straps caught once at release [R18]
               mode_d = mode_s;
               pci_d  = pci_s;
               bige_d = bige_s;
               cnt_d  = 10'h000;
               // Pick one of three boot paths [R02]
               if (mode_s == BMS_BOOT_HOST)
               begin
                  state_d = BMS_ST_HOST_WAIT;   // [R03]
               end
               else if (mode_s == BMS_BOOT_ROM)
               begin
                  state_d = BMS_ST_ROM_READ;    // [R10]
                  rom_d   = '{rd: 1'b1, addr: BMS_CE1_BASE};
               end
               else
               begin
                  // Straight to execution, no copy [R14]
                  state_d = BMS_ST_RUN;
                  start_d = 1'b1;
               end
            end
            BMS_ST_HOST_WAIT:
            begin
               // Wake release is unlatched, no interrupt [R06] [R07]
               if (wake_rise)
               begin
                  state_d = BMS_ST_RUN;
                  start_d = 1'b1;
               end
            end
            BMS_ST_ROM_READ:
            begin
               if (rom_ack)
               begin
                  // Pack bytes in the captured byte order [R11] [R13]
                  word_d = bige_q ? {word_q[23:0], rom_data} : {rom_data, word_q[31:8]};
                  rom_d.rd = 1'b0;
                  if (cnt_q[1:0] == 2'h3)
                  begin
                     state_d = BMS_ST_ROM_WRITE;
                     // Destination is internal memory at zero [R17]
                     mem_d = '{wr: 1'b1, addr: BMS_IMEM_BASE | {22'h0, cnt_q[9:2], 2'h0},
                               data: word_d};
                  end
                  else
                  begin
                     cnt_d = cnt_q + 10'h001;
                     rom_d = '{rd: 1'b1, addr: BMS_CE1_BASE | {22'h0, cnt_d}};
                  end
               end
            end
            BMS_ST_ROM_WRITE:
            begin
               if (mem_ack)
               begin
                  mem_d.wr = 1'b0;
                  // Single block ends after the last word [R12]
                  if (cnt_q == BMS_LAST_BYTE)
                  begin
                     state_d = BMS_ST_RUN;
                     start_d = 1'b1;
                  end
                  else
                  begin
                     state_d = BMS_ST_ROM_READ;
                     cnt_d   = cnt_q + 10'h001;
                     rom_d   = '{rd: 1'b1, addr: BMS_CE1_BASE | {22'h0, cnt_d}};
                  end
               end
            end
            BMS_ST_RUN:
            begin
               // Interrupt only on a fresh wake while running [R09]
               irq_d = wake_rise;
            end
         endcase
      end
   end

   // Outputs follow the next state so they align with it
   always_comb
   begin
      prst_d  = (state_d == BMS_ST_RESET);                             // [R01]
      stall_d = (state_d != BMS_ST_RUN);                               // [R03]
      hpe_d   = (state_d != BMS_ST_RESET) & (mode_d == BMS_BOOT_HOST) & ~pci_d;  // [R04]
      pcie_d  = (state_d != BMS_ST_RESET) & (mode_d == BMS_BOOT_HOST) & pci_d;   // [R04]
      hme_d   = (state_d != BMS_ST_RESET) & (mode_d == BMS_BOOT_HOST); // [R08]
      sel_d   = ce_decode(dec_addr);                                   // [R15] [R16]
   end

   // Register all state
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         state_q <= BMS_ST_RESET;
         mode_q  <= BMS_MODE_RST;
         pci_q   <= 1'b0;
         bige_q  <= 1'b0;
         cnt_q   <= 10'h000;
         word_q  <= 32'h0000_0000;
         wake_q  <= BMS_WAKE_RST;
         irq_q   <= 1'b0;
         start_q <= 1'b0;
         stall_q <= 1'b1;
         prst_q  <= 1'b1;
         hpe_q   <= 1'b0;
         pcie_q  <= 1'b0;
         hme_q   <= 1'b0;
         rom_q   <= '0;
         mem_q   <= '0;
         sel_q   <= 4'h0;
         rdy_q   <= 1'b0;
         err_q   <= 1'b0;
         rdat_q  <= 32'h0000_0000;
      end
      else
      begin
         state_q <= state_d;
         mode_q  <= mode_d;
         pci_q   <= pci_d;
         bige_q  <= bige_d;
         cnt_q   <= cnt_d;
         word_q  <= word_d;
         wake_q  <= wake_d;
         irq_q   <= irq_d;
         start_q <= start_d;
         stall_q <= stall_d;
         prst_q  <= prst_d;
         hpe_q   <= hpe_d;
         pcie_q  <= pcie_d;
         hme_q   <= hme_d;
         rom_q   <= rom_d;
         mem_q   <= mem_d;
         sel_q   <= sel_d;
         rdy_q   <= rdy_d;
         err_q   <= err_d;
         rdat_q  <= rdat_d;
      end
   end

   // Port drive
   assign prdata         = rdat_q;
   assign pready         = rdy_q;
   assign pslverr        = err_q;
   assign periph_rst     = prst_q;
   assign cpu_stall      = stall_q;
   assign cpu_start      = start_q;
   assign cpu_start_addr = BMS_CPU_START;
   assign cpu_wake_irq   = irq_q;
   assign host_port_en   = hpe_q;
   assign pci_en         = pcie_q;
   assign host_mem_en    = hme_q;
   assign rom_req        = rom_q;
   assign mem_req        = mem_q;
   assign dec_sel        = sel_q;

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_reset_hold: assert property (!rst_rel_s |=> periph_rst && cpu_stall) // [R01]
      else $error("reset pin low did not hold device");
   // A falling reset pin may leave the wait state, so the pin must be high
   a_host_stall: assert property (state_q == BMS_ST_HOST_WAIT && !wake_rise // [R03]
      && rst_rel_s |=> cpu_stall && !periph_rst)
      else $error("host boot stall or release wrong");
   a_host_route: assert property (state_q == BMS_ST_HOST_WAIT // [R04]
      |-> host_port_en == !pci_q && pci_en == pci_q)
      else $error("host path not steered by strap");
   a_wake_release: assert property (state_q == BMS_ST_HOST_WAIT && wake_rise // [R06]
      && rst_rel_s |=> !cpu_stall && cpu_start && cpu_start_addr == 32'h0000_0000
      && !cpu_wake_irq)
      else $error("wake did not release the CPU");
   a_stall_no_irq: assert property (cpu_stall |=> !cpu_wake_irq) // [R07]
      else $error("wake interrupt while stalled");
   a_wake_once: assert property (wake_q && !cpu_stall |=> !cpu_wake_irq) // [R09]
      else $error("wake interrupt while bit set");
   a_host_mem: assert property (stall_q && mode_q == BMS_BOOT_HOST && !prst_q // [R08]
      |-> host_mem_en)
      else $error("host memory access blocked");
   a_rom_addr: assert property (rom_req.rd |-> rom_req.addr <= BMS_CE1_LAST // [R10]
      && ce_decode(rom_req.addr) == 4'h2 && rom_req.addr[31:10] == BMS_CE1_BASE[31:10])
      else $error("ROM read outside image");
   a_pack_word: assert property ($rose(mem_req.wr) |-> (bige_q ? mem_req.data[7:0] // [R11]
      : mem_req.data[31:24]) == $past(rom_data))
      else $error("last ROM byte misplaced in word");
   a_copy_done: assert property (state_q == BMS_ST_ROM_WRITE && mem_ack && rst_rel_s // [R12]
      && cnt_q == BMS_LAST_BYTE |=> !cpu_stall && cpu_start)
      else $error("copy end did not release CPU");
   a_no_boot: assert property (state_q == BMS_ST_RESET && rst_rel_s // [R14]
      && mode_s == BMS_BOOT_NONE |=> !cpu_stall ##1 !cpu_start)
      else $error("no boot did not run at once");
   a_decode: assert property (dec_sel == ce_decode($past(dec_addr))) // [R15]
      else $error("chip-enable decode wrong");
   a_strap_hold: assert property (state_q != BMS_ST_RESET // [R18]
      && $past(state_q) != BMS_ST_RESET |-> $stable(mode_q) && $stable(pci_q))
      else $error("straps changed after release");

   c_host_boot: cover property (state_q == BMS_ST_HOST_WAIT ##[1:200] cpu_start);
   c_rom_boot: cover property (state_q == BMS_ST_ROM_WRITE && cnt_q == BMS_LAST_BYTE
      ##1 cpu_start);
   c_wake_irq: cover property (cpu_wake_irq);
   c_apb_err: cover property (pready && pslverr);

endmodule

// file: test/bms_partner.sv
// Far-side model: boot ROM byte source and internal memory write acknowledge.
module bms_partner (
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   input  wire logic                  slow,
   input  wire bms_pkg::bms_rom_req_s rom_req,
   output logic      [7:0]            rom_data,
   output logic                       rom_ack,
   input  wire bms_pkg::bms_mem_req_s mem_req,
   output logic                       mem_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   import bms_pkg::*;

   logic [1:0] wait_q = 2'h0;  // Wait states spent on a read
   logic [7:0] junk_q = 8'h5A; // Filler shown while no byte is driven
   logic       in_img;         // Read falls inside the image

   // Image byte at offset n, stored in the system byte order
   function automatic logic [7:0] rom_byte(input logic [9:0] n);
      return n[7:0] ^ {n[9:8], 6'h2D};
   endfunction

   // Only the first 1 KB of region one holds the image
   assign in_img = (rom_req.addr[31:28] == 4'h9) && (rom_req.addr[27:10] == 18'h0);

   // Answers reads promptly or after three waits; data bus never idles on a value
   always @(posedge clk_sys)
   begin
      junk_q   <= junk_q + 8'h3B;
      rom_ack  <= 1'b0;
      mem_ack  <= 1'b0;
      rom_data <= ~junk_q;
      if (srst)
         wait_q <= 2'h0;
      else if (rom_req.rd && !rom_ack)
      begin
         wait_q <= wait_q + 2'h1;
         // Byte given with the ack only
         if (!slow || wait_q == 2'h3)
         begin
            rom_ack  <= 1'b1;
            rom_data <= in_img ? rom_byte(rom_req.addr[9:0]) : junk_q;
            wait_q   <= 2'h0;
         end
      end
      // Memory stalls now and then when slow
      if (!srst && mem_req.wr && !mem_ack)
         mem_ack <= !slow || junk_q[1];
   end
endmodule

// file: test/bms_top_test.sv
// Self-checking bench for the boot mode sequencer.
module bms_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import bms_pkg::*;

   logic clk_sys = 1'b0, srst = 1'b1, reset_pin_n = 1'b0, slow = 1'b0;
   logic [1:0] boot_mode_pin = 2'h0;
   logic pci_sel_pin = 1'b0, big_endian_pin = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, dec_addr = 32'h0, a;
   logic [31:0] prdata, cpu_start_addr;
   logic pready, pslverr, periph_rst, cpu_stall, cpu_start, cpu_wake_irq;
   logic host_port_en, pci_en, host_mem_en, rom_ack, mem_ack;
   logic [7:0] rom_data;
   logic [3:0] dec_sel;
   bms_rom_req_s rom_req;
   bms_mem_req_s mem_req;
   int num_errors = 0, n_tests = 0, seed = 93483, cyc = 0;
   int n_irq = 0, n_start = 0, n_rd = 0, i, j, k, s0, r0;
   logic [33:0] aq[$], e;       // APB notes: check-data, error, data
   logic [63:0] mq[$];          // Memory write notes: address, word
   int          dq_due[$];      // Decoder note due cycle
   logic [3:0]  dq_v[$];        // Decoder expected select
   logic [7:0]  b[4];
   logic [31:0] tbl[8] = '{32'h0, 32'h7FFF_FFFF, 32'h8000_0000, 32'h8FFF_FFFF,
                           32'h9000_0000, 32'h9FFF_FFFF, 32'hBFFF_FFFF, 32'hC000_0000};

   bms_top bms_top_i (.clk_sys, .srst, .reset_pin_n, .boot_mode_pin, .pci_sel_pin,
      .big_endian_pin, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .periph_rst, .cpu_stall, .cpu_start, .cpu_start_addr, .cpu_wake_irq,
      .host_port_en, .pci_en, .host_mem_en, .rom_req, .rom_data, .rom_ack, .mem_req,
      .mem_ack, .dec_addr, .dec_sel);
   bms_partner bms_partner_i (.clk_sys, .srst, .slow, .rom_req, .rom_data, .rom_ack,
      .mem_req, .mem_ack);

   // Clock and cycle count
   always #10 clk_sys = ~clk_sys;
   always @(negedge clk_sys) cyc++;

   // Compare and report
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task wrap_up;
      if (num_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Status word from its fields
   function automatic logic [31:0] st(input logic sl, h, c, p, input logic [1:0] m,
                                      input logic be);
      st = 32'h0;
      st[BMS_ST_STALL] = sl;
      st[BMS_ST_HOST] = h;
      st[BMS_ST_COPY] = c;
      st[BMS_ST_PCI] = p;
      st[BMS_ST_MODE +: 2] = m;
      st[BMS_ST_BIGEND] = be;
   endfunction

   // One APB transfer; the answer is judged by the monitor
   task apb(input logic wr, input logic [31:0] ad, input logic [31:0] d,
            input logic [33:0] ex);
      int n;
      aq.push_back(ex);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk_sys);
         if (pready === 1'b1) break;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20)
      begin
         chk(0, 1);
         wrap_up();
      end
   endtask

   // Bounded wait for the CPU to leave its stall
   task wait_low(input int lim);
      int n;
      for (n = 0; n < lim; n++)
      begin
         @(posedge clk_sys);
         if (cpu_stall === 1'b0) break;
      end
      if (n == lim)
      begin
         chk(0, 1);
         wrap_up();
      end
      repeat (2) @(posedge clk_sys);
   endtask

   // Pin reset with straps, then release
   task boot(input logic [1:0] m, input logic p, input logic be);
      @(posedge clk_sys);
      reset_pin_n <= 1'b0;
      boot_mode_pin <= m;
      pci_sel_pin <= p;
      big_endian_pin <= be;
      repeat (6) @(posedge clk_sys);
      chk({periph_rst, cpu_stall}, 2'b11);
      // Counts taken before release: a start may come three edges after it
      s0 = n_start;
      r0 = n_rd;
      reset_pin_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk(periph_rst, 0);
   endtask

   // Output monitor: takes the oldest note when a result shows
   always @(posedge clk_sys)
   begin
      if (pready === 1'b1)
      begin
         e = aq.size() ? aq.pop_front() : 34'h3_FFFF_FFFF;
         if (e[33]) chk({pslverr, prdata}, e[32:0]);
         else chk(pslverr, e[32]);
      end
      if (mem_req.wr && mem_ack)
         chk({mem_req.addr, mem_req.data}, mq.size() ? mq.pop_front() : 64'hX);
      if (dq_v.size() && dq_due[0] == cyc)
      begin
         chk(dec_sel, dq_v.pop_front());
         dq_due.pop_front();
      end
      if (cpu_start === 1'b1)
      begin
         n_start++;
         chk({cpu_stall, cpu_start_addr}, {1'b0, BMS_CPU_START});
      end
      if (cpu_wake_irq === 1'b1) n_irq++;
      if (rom_req.rd && rom_ack) n_rd++;
   end

   // Overall watchdog
   initial
   begin
      repeat (100000) @(posedge clk_sys);
      chk(0, 1);
      wrap_up();
   end

   // Main sequence
   initial
   begin
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      // Host boot over the host port
      boot(BMS_BOOT_HOST, 1'b0, 1'b0);
      chk({host_port_en, pci_en, host_mem_en, cpu_stall}, 4'b1011);
      boot_mode_pin <= BMS_BOOT_ROM;
      pci_sel_pin <= 1'b1;
      apb(0, BMS_STAT_OFFS, 0, {2'b10, st(1, 1, 0, 0, BMS_BOOT_HOST, 0)});
      apb(0, 32'h8, 0, {2'b11, 32'h0});
      apb(1, 32'hC, 32'h1, {2'b01, 32'h0});
      apb(0, BMS_HPC_OFFS, 0, {2'b10, 32'h0});
      chk(cpu_stall, 1);
      apb(1, BMS_HPC_OFFS, 1, 34'h0); // Host finishes loading
      wait_low(10);
      chk({n_start, n_irq}, {s0 + 1, 32'd0});
      apb(1, BMS_HPC_OFFS, 1, 34'h0);
      apb(1, BMS_HPC_OFFS, 0, 34'h0);
      repeat (2) @(posedge clk_sys);
      chk(n_irq, 0);
      apb(1, BMS_HPC_OFFS, 1, 34'h0);
      repeat (2) @(posedge clk_sys);
      chk(n_irq, 1);
      apb(0, BMS_STAT_OFFS, 0, {2'b10, st(0, 1, 0, 0, BMS_BOOT_HOST, 0)});
      // Host boot over PCI
      boot(BMS_BOOT_HOST, 1'b1, 1'b0);
      chk({host_port_en, pci_en, cpu_stall}, 3'b011);
      // ROM copy, little endian prompt then big endian slow
      for (k = 0; k < 2; k++)
      begin
         slow <= k[0];
         for (i = 0; i < 256; i++)
         begin
            for (j = 0; j < 4; j++) b[j] = bms_partner_i.rom_byte(10'(4 * i + j));
            mq.push_back({32'(4 * i), k ? {b[0], b[1], b[2], b[3]} : {b[3], b[2], b[1], b[0]}});
         end
         boot(BMS_BOOT_ROM, 1'b0, k[0]);
         apb(1, BMS_HPC_OFFS, 1, 34'h0);
         apb(0, BMS_STAT_OFFS, 0, {2'b10, st(1, 0, 1, 0, BMS_BOOT_ROM, k[0])});
         chk({cpu_stall, n_irq}, {1'b1, 32'd1});
         wait_low(20000);
         chk(n_rd - r0, 1024);
         chk({mq.size(), n_start}, {32'd0, s0 + 1});
      end
      // No boot, codes 0 and 3
      for (k = 0; k < 4; k += 3)
      begin
         boot(2'(k), 1'b0, 1'b0);
         wait_low(10);
         chk(n_rd - r0, 0);
         chk({n_start, host_mem_en}, {s0 + 1, 1'b0});
      end
      // Region decode: boundaries, then random addresses
      for (i = 0; i < 40; i++)
      begin
         @(posedge clk_sys);
         a = (i < 8) ? tbl[i] : $random(seed);
         dec_addr <= a;
         dq_due.push_back(cyc + 2);
         dq_v.push_back(a[31:30] == 2'b10 ? 4'h1 << a[29:28] : 4'h0);
      end
      repeat (3) @(posedge clk_sys);
      wrap_up();
   end
endmodule
